// file: src/psp_stage_group.sv
/*
 * Power stage grouping and diagnosis timing for four high-side and four
 * low-side stages, with a classic Wishbone register slave and one interrupt.
 * Assumes stage pins and comparators are asynchronous to sys_clk; srst is
 * synchronous to sys_clk.
 */
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module psp_stage_group #(
    parameter logic [psp_pkg::MASK_CNT_W-1:0] MASK_CYC = psp_pkg::DIAG_MASK_CYC,
    parameter logic [psp_pkg::HOLD_CNT_W-1:0] HOLD_LIMIT = psp_pkg::HOLD_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] stageCmd,
    input wire logic [7:0] overcurrentSense,
    input wire logic [7:0] offDiagSense,
    input wire logic low_battery_indication,
    output logic [7:0] stageDrive,
    output logic irq
);
    typedef struct packed {
        logic [7:0] cfg;
        logic [15:0] status;
        logic [15:0] mask;
        logic ack;
        logic [31:0] rdata;
        logic [2:0][7:0] cmdSync;
        logic [2:0][7:0] ocSync;
        logic [2:0][7:0] diagSync;
        logic [2:0] lbSync;
        logic [7:0] cmdFilt;
        logic [7:0] ocFilt;
        logic [7:0] diagFilt;
        logic lbFilt;
        logic [7:0] stageOn;
        logic [7:0][psp_pkg::OC_CNT_W-1:0] ocCnt;
        logic [7:0][psp_pkg::OC_CNT_W-1:0] diagCnt;
        logic [7:0][psp_pkg::MASK_CNT_W-1:0] maskCnt;
        logic [1:0][psp_pkg::HOLD_CNT_W-1:0] holdCnt;
    } psp_state_t;

    psp_state_t s;
    psp_state_t n;
    logic [4:0] cfgKey;
    logic [7:0][2:0] drv;
    logic [7:0][2:0] dg;
    logic [7:0] grouped;
    logic [7:0] tgt;
    logic [7:0] trip;
    logic busReq;

    assign cfgKey = {s.cfg[7], s.cfg[3:0]};
    assign busReq = wb_cyc_i & wb_stb_i & ~s.ack;

    // Bits 6..4 select combined modes, which this block does not decode
    always_comb begin
        drv = psp_pkg::IDENT_MAP;
        dg = psp_pkg::IDENT_MAP;
        grouped = 8'h00;
        case (cfgKey)
            psp_pkg::KEY_LOW_PAIR: begin
                drv[4] = psp_pkg::LOW_SIDE_B;
                dg[4] = psp_pkg::LOW_SIDE_A;
                dg[5] = psp_pkg::LOW_SIDE_A;
                grouped = 8'h30;
            end
            psp_pkg::KEY_LOW_TWO_PAIRS: begin
                drv[4] = psp_pkg::LOW_SIDE_B;
                dg[4] = psp_pkg::LOW_SIDE_A;
                dg[5] = psp_pkg::LOW_SIDE_A;
                drv[7] = psp_pkg::LOW_SIDE_C;
                dg[7] = psp_pkg::LOW_SIDE_C;
                grouped = 8'hF0;
            end
            psp_pkg::KEY_LOW_QUAD: begin
                for (int i = 4; i < 8; i++) begin
                    drv[i] = psp_pkg::LOW_SIDE_B;
                    dg[i] = psp_pkg::LOW_SIDE_A;
                end
                grouped = 8'hF0;
            end
            psp_pkg::KEY_HIGH_PAIR: begin
                drv[0] = psp_pkg::HIGH_SIDE_B;
                dg[0] = psp_pkg::HIGH_SIDE_A;
                dg[1] = psp_pkg::HIGH_SIDE_A;
                grouped = 8'h03;
            end
            psp_pkg::KEY_HIGH_TWO_PAIRS: begin
                drv[0] = psp_pkg::HIGH_SIDE_B;
                dg[0] = psp_pkg::HIGH_SIDE_A;
                dg[1] = psp_pkg::HIGH_SIDE_A;
                drv[3] = psp_pkg::HIGH_SIDE_C;
                dg[3] = psp_pkg::HIGH_SIDE_C;
                grouped = 8'h0F;
            end
            psp_pkg::KEY_HIGH_QUAD: begin
                for (int i = 0; i < 4; i++) begin
                    drv[i] = psp_pkg::HIGH_SIDE_B;
                    dg[i] = psp_pkg::HIGH_SIDE_A;
                end
                grouped = 8'h0F;
            end
            psp_pkg::KEY_HIGH_TRIPLE: begin
                for (int i = 1; i < 4; i++) begin
                    drv[i] = psp_pkg::HIGH_SIDE_B;
                    dg[i] = psp_pkg::HIGH_SIDE_C;
                end
                grouped = 8'h0E;
            end
            psp_pkg::KEY_LOW_TRIPLE: begin
                for (int i = 5; i < 8; i++) begin
                    drv[i] = psp_pkg::LOW_SIDE_B;
                    dg[i] = psp_pkg::LOW_SIDE_B;
                end
                grouped = 8'hE0;
            end
            default: begin
                grouped = 8'h00;
            end
        endcase
    end

    // Whole group follows its driving input; a latched overcurrent fault on the reporting stage keeps it off
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            trip[i] = s.status[dg[i]];
            tgt[i] = s.cmdFilt[drv[i]] & ~trip[i];
        end
    end

    always_comb begin
        logic [15:0] setBits;
        logic [15:0] clrBits;
        logic [psp_pkg::OC_CNT_W-1:0] ocLim;
        setBits = 16'h0000;
        clrBits = 16'h0000;
        ocLim = psp_pkg::OC_SINGLE_CYC;
        n = s;

        // Pin inputs: three stages, a change counts once stages two and three agree
        n.cmdSync = {s.cmdSync[1:0], stageCmd};
        n.ocSync = {s.ocSync[1:0], overcurrentSense};
        n.diagSync = {s.diagSync[1:0], offDiagSense};
        n.lbSync = {s.lbSync[1:0], low_battery_indication};
        n.cmdFilt = (s.cmdFilt & (s.cmdSync[1] ^ s.cmdSync[2])) | (s.cmdSync[2] & ~(s.cmdSync[1] ^ s.cmdSync[2]));
        n.ocFilt = (s.ocFilt & (s.ocSync[1] ^ s.ocSync[2])) | (s.ocSync[2] & ~(s.ocSync[1] ^ s.ocSync[2]));
        n.diagFilt = (s.diagFilt & (s.diagSync[1] ^ s.diagSync[2])) |
            (s.diagSync[2] & ~(s.diagSync[1] ^ s.diagSync[2]));
        n.lbFilt = (s.lbSync[1] == s.lbSync[2]) ? s.lbSync[2] : s.lbFilt;

        // Bus slave: ack one cycle after the request, dropped the cycle after
        n.ack = busReq;
        if (busReq) begin
            n.rdata = 32'h0000_0000;
            if (wb_adr_i == psp_pkg::ADR_CMD) begin
                n.rdata = {24'h00_0000, s.cfg};
                if (wb_we_i && wb_sel_i[1:0] == 2'h3 &&
                    wb_dat_i[psp_pkg::CMD_CODE_LSB +: 6] == psp_pkg::WRITE_STAGE_GROUPING_CMD) begin
                    n.cfg = wb_dat_i[7:0];
                end
            end else if (wb_adr_i == psp_pkg::ADR_STATUS) begin
                n.rdata = {16'h0000, s.status};
                if (wb_we_i) begin
                    clrBits = wb_dat_i[15:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
                end
            end else if (wb_adr_i == psp_pkg::ADR_MASK) begin
                n.rdata = {16'h0000, s.mask};
                if (wb_we_i && wb_sel_i[0]) begin
                    n.mask[7:0] = wb_dat_i[7:0];
                end
                if (wb_we_i && wb_sel_i[1]) begin
                    n.mask[15:8] = wb_dat_i[15:8];
                end
            end else if (wb_adr_i == psp_pkg::ADR_STATE) begin
                n.rdata = {15'h0000, s.lbFilt, grouped, s.stageOn};
            end
        end

        for (int i = 0; i < 8; i++) begin
            // Grouping doubles the overcurrent filter; thresholds stay per stage
            ocLim = grouped[i] ? psp_pkg::OC_GROUP_CYC : psp_pkg::OC_SINGLE_CYC;

            // Low battery hold applies to high-side A and C only
            if ((i == 0 || i == 2) && s.stageOn[i] && !tgt[i] && !trip[i] && s.lbFilt) begin
                if (s.holdCnt[i/2] >= HOLD_LIMIT - 1'b1) begin
                    n.stageOn[i] = 1'b0;
                    n.holdCnt[i/2] = '0;
                end else begin
                    n.holdCnt[i/2] = s.holdCnt[i/2] + 1'b1;
                end
            end else begin
                n.stageOn[i] = tgt[i];
                if (i == 0 || i == 2) begin
                    n.holdCnt[i/2] = '0;
                end
            end

            // Off-state diagnosis stays blind until the mask runs out
            if (s.stageOn[i] && !n.stageOn[i]) begin
                n.maskCnt[i] = MASK_CYC;
            end else if (s.maskCnt[i] != '0) begin
                n.maskCnt[i] = s.maskCnt[i] - 1'b1;
            end

            if (s.stageOn[i] && s.ocFilt[i] && !trip[i]) begin
                n.ocCnt[i] = s.ocCnt[i] + 1'b1;
                if (s.ocCnt[i] + 1'b1 == ocLim) begin
                    setBits[dg[i]] = 1'b1;
                end
            end else begin
                n.ocCnt[i] = '0;
            end

            if (!s.stageOn[i] && s.maskCnt[i] == '0 && s.diagFilt[i]) begin
                if (s.diagCnt[i] != psp_pkg::DIAG_FILTER_CYC) begin
                    n.diagCnt[i] = s.diagCnt[i] + 1'b1;
                end
                if (s.diagCnt[i] + 1'b1 == psp_pkg::DIAG_FILTER_CYC) begin
                    setBits[psp_pkg::DIAG_STATUS_LSB + 32'(dg[i])] = 1'b1;
                end
            end else begin
                n.diagCnt[i] = '0;
            end
        end

        // A fresh event outlives a simultaneous write-one-to-clear
        n.status = (s.status & ~clrBits) | setBits;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s <= '0;
            s.cfg <= psp_pkg::CFG_RESET;
        end else begin
            s <= n;
        end
    end

    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;
    assign stageDrive = s.stageOn;
    assign irq = |(s.status & s.mask);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    cfg_load_a: assert property (
        busReq && wb_we_i && wb_adr_i == psp_pkg::ADR_CMD && wb_sel_i[1:0] == 2'h3 &&
        wb_dat_i[13:8] == psp_pkg::WRITE_STAGE_GROUPING_CMD |=> s.cfg == $past(wb_dat_i[7:0]))
        else $error("grouping config not loaded by write command");
    cfg_reset_a: assert property (@(posedge sys_clk) disable iff (1'b0) $past(srst) |-> s.cfg == 8'h00)
        else $error("grouping config not cleared by reset");
    single_map_a: assert property (cfgKey == 5'h00 |-> drv == psp_pkg::IDENT_MAP && dg == psp_pkg::IDENT_MAP)
        else $error("ungrouped stage not mapped to itself");
    low_pair_a: assert property (
        cfgKey == 5'h02 |-> drv[4] == 3'h5 && drv[5] == 3'h5 && dg[4] == 3'h4 && dg[5] == 3'h4 && drv[6] == 3'h6)
        else $error("low pair mapping wrong");
    high_quad_a: assert property (
        cfgKey == 5'h0A |-> drv[0] == 3'h1 && drv[3] == 3'h1 && dg[2] == 3'h0 && grouped == 8'h0F)
        else $error("high quad mapping wrong");
    oc_single_a: assert property (
        cfgKey == 5'h00 && $rose(s.status[0]) |-> $past(s.ocCnt[0]) == 7'd39 && $past(s.ocFilt[0], 40))
        else $error("single overcurrent filter time wrong");
    oc_group_a: assert property (
        cfgKey == 5'h0A && $past(cfgKey) == 5'h0A && $rose(s.status[0]) |->
        $past(s.ocCnt[0]) == 7'd79 || $past(s.ocCnt[1]) == 7'd79 ||
        $past(s.ocCnt[2]) == 7'd79 || $past(s.ocCnt[3]) == 7'd79)
        else $error("grouped overcurrent filter not 8 us");
    oc_off_a: assert property ($rose(s.status[0]) && cfgKey == 5'h00 |=> !s.stageOn[0])
        else $error("stage left on after overcurrent");
    diag_filter_a: assert property (
        cfgKey == 5'h00 && $rose(s.status[8]) |-> $past(s.diagCnt[0]) == 7'd99 && !$past(s.stageOn[0]))
        else $error("off diagnosis confirmed early");
    diag_mask_a: assert property ($fell(s.stageOn[0]) |-> s.maskCnt[0] == MASK_CYC ##1 s.diagCnt[0] == 7'd0)
        else $error("diagnosis not masked after switch off");
    lb_hold_a: assert property (
        s.stageOn[0] && !tgt[0] && !trip[0] && s.lbFilt && s.holdCnt[0] == 22'd0 |=> s.stageOn[0] [*8])
        else $error("low battery hold not kept");
endmodule

// file: shared/psp_pkg.sv
/*
 * Constants for the power stage parallelism block: register map, command code,
 * grouping keys, stage indices and filter timing.
 * Assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
 */
// Functional notes
// - Write command 110011 loads 8-bit grouping config.
// - Ungrouped stages drive and diagnose themselves.
// - Grouped stages use 8 us overcurrent filter.
// - Key 00010: low A+B, drive B, diag A.
// - Key 00100: low A+B and C+D pairs.
// - Key 01000: all low, drive B, diag A.
// - Key 00110: high A+B, drive B, diag A.
// - Key 01110: high A+B and C+D pairs.
// - Key 01010: all high, drive B, diag A.
// - Key 10100: high B,C,D, drive B, diag C.
// - Key 11100: low B,C,D, drive/diag B.
// - Single stage overcurrent reported after filter time.
// - Off-state diagnosis confirmed after 7-13 us.
// - Off-state diagnosis masked 1.2-1.6 ms after off.
// - High A/C hold on 400-800 ms at low battery.
// - Grouped stages keep own diagnosis thresholds.
package psp_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int OC_FILTER_SINGLE_NS = 4000;
    localparam int OC_FILTER_GROUP_NS = 8000;
    localparam int OFF_DIAG_FILTER_NS = 10000;
    localparam int DIAG_MASK_US = 1200;
    localparam int HOLD_DELAY_MS = 400;

    localparam int OC_CNT_W = 7;
    localparam int MASK_CNT_W = 14;
    localparam int HOLD_CNT_W = 22;

    localparam logic [OC_CNT_W-1:0] OC_SINGLE_CYC =
        OC_CNT_W'((OC_FILTER_SINGLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [OC_CNT_W-1:0] OC_GROUP_CYC =
        OC_CNT_W'((OC_FILTER_GROUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [OC_CNT_W-1:0] DIAG_FILTER_CYC =
        OC_CNT_W'((OFF_DIAG_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [MASK_CNT_W-1:0] DIAG_MASK_CYC =
        MASK_CNT_W'((DIAG_MASK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [HOLD_CNT_W-1:0] HOLD_CYC =
        HOLD_CNT_W'((HOLD_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam logic [7:0] ADR_CMD = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_MASK = 8'h08;
    localparam logic [7:0] ADR_STATE = 8'h0C;

    localparam int CMD_CODE_LSB = 8;
    localparam logic [5:0] WRITE_STAGE_GROUPING_CMD = 6'h33;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int DIAG_STATUS_LSB = 8;

    localparam logic [2:0] HIGH_SIDE_A = 3'h0;
    localparam logic [2:0] HIGH_SIDE_B = 3'h1;
    localparam logic [2:0] HIGH_SIDE_C = 3'h2;
    localparam logic [2:0] HIGH_SIDE_D = 3'h3;
    localparam logic [2:0] LOW_SIDE_A = 3'h4;
    localparam logic [2:0] LOW_SIDE_B = 3'h5;
    localparam logic [2:0] LOW_SIDE_C = 3'h6;
    localparam logic [2:0] LOW_SIDE_D = 3'h7;
    localparam logic [23:0] IDENT_MAP = 24'hFAC688;

    // Key is {bit7, bit3, bit2, bit1, bit0}
    localparam logic [4:0] KEY_LOW_PAIR = 5'h02;
    localparam logic [4:0] KEY_LOW_TWO_PAIRS = 5'h04;
    localparam logic [4:0] KEY_LOW_QUAD = 5'h08;
    localparam logic [4:0] KEY_HIGH_PAIR = 5'h06;
    localparam logic [4:0] KEY_HIGH_TWO_PAIRS = 5'h0E;
    localparam logic [4:0] KEY_HIGH_QUAD = 5'h0A;
    localparam logic [4:0] KEY_HIGH_TRIPLE = 5'h14;
    localparam logic [4:0] KEY_LOW_TRIPLE = 5'h1C;
endpackage

// file: verification/psp_host_model.sv
/*
 * Host side model: a classic Wishbone master that runs one single cycle per
 * request from the bench and reports completion with a one-cycle done pulse.
 * Assumes the slave answers with a registered one-cycle ack.
 */
`timescale 1ns/1ps
module psp_host_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic req,
    input wire logic reqWe,
    input wire logic [7:0] reqAdr,
    input wire logic [31:0] reqDat,
    output logic done = 1'b0,
    output logic [31:0] rdat = 32'h00000000,
    output logic wbCyc = 1'b0,
    output logic wbStb = 1'b0,
    output logic wbWe = 1'b0,
    output logic [7:0] wbAdr = 8'h00,
    output logic [3:0] wbSel = 4'h0,
    output logic [31:0] wbDat = 32'h00000000,
    input wire logic wbAck,
    input wire logic [31:0] wbDatIn
);
    always @(posedge sys_clk) begin
        done <= 1'b0;
        if (srst) begin
            wbCyc <= 1'b0;
            wbStb <= 1'b0;
        end else if (wbCyc && wbAck) begin
            // Released we, address and data lines show inverted values; wbSel keeps a stale copy
            rdat <= wbDatIn;
            done <= 1'b1;
            wbCyc <= 1'b0;
            wbStb <= 1'b0;
            wbWe <= ~wbWe;
            wbAdr <= ~wbAdr;
            wbDat <= ~wbDat;
        end else if (!wbCyc && req && !done) begin
            wbCyc <= 1'b1;
            wbStb <= 1'b1;
            wbWe <= reqWe;
            wbAdr <= reqAdr;
            wbSel <= 4'hF;
            wbDat <= reqDat;
        end
    end
endmodule

// file: verification/psp_stage_group_tb.sv
/*
 * Self-checking bench for the stage grouping block: register access through
 * the host model, grouping table, overcurrent, off-state diagnosis, low battery.
 * Assumes shortened mask and hold counts set at the instance.
 */
`timescale 1ns/1ps
module psp_stage_group_tb;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic req = 1'b0;
    logic reqWe = 1'b0;
    logic [7:0] reqAdr = 8'h00;
    logic [31:0] reqDat = 32'h00000000;
    logic [31:0] rdat, wbDatO, wbDatI, q;
    logic done, wbCyc, wbStb, wbWe, wbAck, irq;
    logic [7:0] wbAdr, stageDrive;
    logic [3:0] wbSel;
    logic [7:0] stageCmd = 8'h00;
    logic [7:0] ocSense = 8'h00;
    logic [7:0] odSense = 8'h00;
    logic lowBat = 1'b0;
    int fail_count = 0;
    int compares = 0;
    localparam logic [7:0] CFG_T [8] = '{8'h02, 8'h04, 8'h08, 8'h06, 8'h0E, 8'h0A, 8'h84, 8'h8C};
    localparam logic [7:0] DRV_T [8] = '{8'h21, 8'h41, 8'h21, 8'h12, 8'h14, 8'h12, 8'h03, 8'h30};
    localparam logic [7:0] EXP_T [8] = '{8'h31, 8'hC1, 8'hF1, 8'h13, 8'h1C, 8'h1F, 8'h0F, 8'hF0};

    initial forever #50 sys_clk = ~sys_clk;

    psp_host_model i_host (.sys_clk(sys_clk), .srst(srst), .req(req), .reqWe(reqWe), .reqAdr(reqAdr),
        .reqDat(reqDat), .done(done), .rdat(rdat), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDat(wbDatI), .wbAck(wbAck), .wbDatIn(wbDatO));

    psp_stage_group #(.MASK_CYC(14'h0014), .HOLD_LIMIT(22'h000010)) i_dut (.sys_clk(sys_clk), .srst(srst),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .stageCmd(stageCmd),
        .overcurrentSense(ocSense), .offDiagSense(odSense), .low_battery_indication(lowBat),
        .stageDrive(stageDrive), .irq(irq));

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chkReg(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chkPin(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        req <= 1'b1;
        reqWe <= we;
        reqAdr <= a;
        reqDat <= d;
        do begin
            @(negedge sys_clk);
            n++;
        end while (done !== 1'b1 && n < 50);
        if (done !== 1'b1) begin
            fail_count++;
            print_verdict();
        end
        @(posedge sys_clk);
        req <= 1'b0;
        q = rdat;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, a, 32'h00000000);
        chkReg(name, exp, q);
    endtask

    task automatic wrCfg(input logic [7:0] cfg);
        bus(1'b1, psp_pkg::ADR_CMD, {18'h00000, psp_pkg::WRITE_STAGE_GROUPING_CMD, cfg});
    endtask

    task automatic setIn(input logic [7:0] cmd, input logic [7:0] oc, input logic [7:0] od, input logic lb);
        @(posedge sys_clk);
        stageCmd <= cmd;
        ocSense <= oc;
        odSense <= od;
        lowBat <= lb;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        rdChk(psp_pkg::ADR_CMD, 32'h00000000, "config");
        rdChk(psp_pkg::ADR_STATUS, 32'h00000000, "status");
        rdChk(psp_pkg::ADR_MASK, 32'h00000000, "mask");
        bus(1'b1, 8'h14, 32'hFFFFFFFF);
        rdChk(8'h10, 32'h00000000, "unmapped");
        setIn(8'hA5, 8'h00, 8'h00, 1'b0);
        tick(6);
        chkPin("single drive", 8'hA5, stageDrive);
        rdChk(psp_pkg::ADR_STATE, 32'h000000A5, "state");
        for (int i = 0; i < 8; i++) begin
            wrCfg(CFG_T[i]);
            rdChk(psp_pkg::ADR_CMD, {24'h000000, CFG_T[i]}, "config");
            setIn(DRV_T[i], 8'h00, 8'h00, 1'b0);
            tick(6);
            chkPin("group drive", EXP_T[i], stageDrive);
        end
        // Wrong command code must leave the grouping alone
        bus(1'b1, psp_pkg::ADR_CMD, {18'h00000, 6'h32, 8'h00});
        rdChk(psp_pkg::ADR_CMD, {24'h000000, CFG_T[7]}, "config");
        wrCfg(8'h00);
        setIn(8'h01, 8'h00, 8'h00, 1'b0);
        tick(6);
        setIn(8'h01, 8'h01, 8'h00, 1'b0);
        tick(38);
        chkPin("oc single early", 8'h01, stageDrive);
        tick(10);
        chkPin("oc single off", 8'h00, stageDrive);
        rdChk(psp_pkg::ADR_STATUS, 32'h00000001, "status");
        chkPin("irq masked", 8'h00, {7'h00, irq});
        bus(1'b1, psp_pkg::ADR_MASK, 32'h00000101);
        chkPin("irq", 8'h01, {7'h00, irq});
        setIn(8'h01, 8'h00, 8'h00, 1'b0);
        tick(6);
        bus(1'b1, psp_pkg::ADR_STATUS, 32'h00000001);
        tick(3);
        chkPin("irq cleared", 8'h00, {7'h00, irq});
        chkPin("oc released", 8'h01, stageDrive);
        wrCfg(8'h0A);
        setIn(8'h02, 8'h00, 8'h00, 1'b0);
        tick(6);
        setIn(8'h02, 8'h0F, 8'h00, 1'b0);
        tick(78);
        chkPin("oc group early", 8'h0F, stageDrive);
        tick(10);
        chkPin("oc group off", 8'h00, stageDrive);
        rdChk(psp_pkg::ADR_STATUS, 32'h00000001, "status");
        setIn(8'h02, 8'h00, 8'h00, 1'b0);
        tick(6);
        bus(1'b1, psp_pkg::ADR_STATUS, 32'h00000001);
        wrCfg(8'h00);
        setIn(8'h01, 8'h00, 8'h00, 1'b0);
        tick(6);
        setIn(8'h00, 8'h00, 8'h01, 1'b0);
        tick(110);
        rdChk(psp_pkg::ADR_STATUS, 32'h00000000, "diag masked");
        tick(25);
        rdChk(psp_pkg::ADR_STATUS, 32'h00000100, "diag confirmed");
        chkPin("irq diag", 8'h01, {7'h00, irq});
        setIn(8'h00, 8'h00, 8'h00, 1'b1);
        bus(1'b1, psp_pkg::ADR_STATUS, 32'h00000100);
        tick(6);
        setIn(8'h03, 8'h00, 8'h00, 1'b1);
        tick(6);
        chkPin("lb on", 8'h03, stageDrive);
        setIn(8'h00, 8'h00, 8'h00, 1'b1);
        tick(12);
        chkPin("lb hold", 8'h01, stageDrive);
        tick(18);
        chkPin("lb release", 8'h00, stageDrive);
        print_verdict();
    end
endmodule
